/* File: rtl/cbslc_line_coder.sv */
// bit level line coder: nrz levels, wired-and view, stuffing, destuffing
// assumes frame logic and bit timing supply one strobe per bit time
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - any dominant driver makes the bus dominant; wired-and resolution
// - bus recessive when nobody drives dominant; idle output stays recessive
// - nrz coding: low is dominant, high recessive, held whole bit
// - after five equal transmitted bits insert one opposite stuff bit
// - never more than five equal consecutive tx line bits inside a frame
// - receiver counts equal bits and deletes each stuff bit
// - frame starts with dominant start bit; counters start from it
module cbslc_line_coder (
  input  wire logic       i_clk_sys,      // core clock, 250 mhz
  input  wire logic       i_nrst,         // async reset, active low
  input  wire logic       i_bit_stb,      // bit boundary strobe from bit timing
  input  wire logic       i_tx_en,        // frame logic is sending a frame
  input  wire logic       i_tx_sof,       // current tx bit is start of frame
  input  wire logic       i_tx_bit,       // unstuffed tx bit, 0 dominant
  output logic            o_tx_ready,     // tx bit taken at this strobe
  input  wire logic       i_rx_line,      // received line level from transceiver
  input  wire logic       i_rx_sof,       // receiver sees start of frame now
  input  wire logic       i_rx_en,        // receiver inside a frame
  output logic            o_tx_line,      // line level to transceiver, 0 dominant
  output logic            o_bus_dominant, // resolved bus is dominant
  output logic            o_rx_valid,     // pulse: destuffed bit valid
  output logic            o_rx_bit,       // destuffed bit
  output logic            o_rx_stuff      // pulse: a stuff bit was dropped
);
  import cbslc_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // a run has reached the stuffing limit
  function automatic logic run_full(input logic [2:0] run);
    return (run == RUN_LIMIT_C);
  endfunction

  // ****************************************************************
  // transmit stuffing
  // ****************************************************************
  cbslc_tx_e  tx_state_q;
  cbslc_tx_e  tx_state_d;
  logic       tx_line_q;
  logic       tx_line_d;
  logic [2:0] tx_run;
  logic       tx_lvl;
  logic       tx_active;
  logic       tx_send;
  logic       tx_stuff_due;
  logic       tx_restart;
  logic       tx_count;
  logic       tx_next;

  // stuff is due when the last sent bit closed a run of five
  assign tx_active    = (tx_state_q != CBSLC_TX_IDLE);
  assign tx_stuff_due = tx_active && run_full(tx_run);
  assign tx_send      = i_bit_stb && i_tx_en && !tx_stuff_due;
  assign o_tx_ready   = tx_send;

  // next state and line level, stepping only on a bit strobe
  always_comb begin
    tx_state_d = tx_state_q;
    tx_line_d  = tx_line_q;
    if (i_bit_stb) begin
      case (tx_state_q)
        CBSLC_TX_IDLE: begin
          if (i_tx_en && i_tx_sof) begin
            tx_state_d = CBSLC_TX_DATA;
            tx_line_d  = LVL_DOMINANT;
          end else begin
            tx_line_d  = LVL_RECESSIVE;
          end
        end
        CBSLC_TX_DATA, CBSLC_TX_STUFF: begin
          if (!i_tx_en) begin
            tx_state_d = CBSLC_TX_IDLE;
            tx_line_d  = LVL_RECESSIVE;
          end else if (tx_stuff_due) begin
            tx_state_d = CBSLC_TX_STUFF;
            tx_line_d  = ~tx_lvl;
          end else begin
            tx_state_d = CBSLC_TX_DATA;
            tx_line_d  = i_tx_bit;
          end
        end
        default: begin
          tx_state_d = CBSLC_TX_IDLE;
          tx_line_d  = LVL_RECESSIVE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_state_q <= CBSLC_TX_IDLE;
    end else begin
      tx_state_q <= tx_state_d;
    end
  end

  // the line only moves at a strobe, so each level stands a whole bit
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_line_q <= LVL_RECESSIVE;
    end else begin
      tx_line_q <= tx_line_d;
    end
  end

  // the counter follows the line, so the start bit counts as dominant
  assign tx_restart = !tx_active;
  assign tx_count   = i_bit_stb && i_tx_en && (tx_active || i_tx_sof);
  assign tx_next    = tx_restart ? LVL_DOMINANT : (tx_stuff_due ? ~tx_lvl : i_tx_bit);

  cbslc_run_counter u_tx_run (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_restart (tx_restart),
    .i_bit_stb (tx_count),
    .i_bit_val (tx_next),
    .o_run     (tx_run),
    .o_lvl     (tx_lvl)
  );

  assign o_tx_line = tx_line_q;

  // ****************************************************************
  // bus view
  // ****************************************************************
  logic bus_dom_q;
  logic bus_dom_d;

  // line is low if we or any other node drive dominant
  assign bus_dom_d = (i_rx_line == LVL_DOMINANT) || (tx_line_q == LVL_DOMINANT);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_dom_q <= 1'b0;
    end else begin
      bus_dom_q <= bus_dom_d;
    end
  end

  assign o_bus_dominant = bus_dom_q;

  // ****************************************************************
  // receive destuffing
  // ****************************************************************
  logic [2:0] rx_run;
  logic       rx_take;
  logic       rx_is_stuff;
  logic       rx_level;
  logic       rx_valid_q;
  logic       rx_valid_d;
  logic       rx_stuff_q;
  logic       rx_stuff_d;
  logic       rx_bit_q;
  logic       rx_bit_d;

  // a dominant on any driver wins over recessive
  assign rx_level    = i_rx_line & tx_line_q;
  assign rx_take     = i_bit_stb && (i_rx_en || i_rx_sof);
  assign rx_is_stuff = !i_rx_sof && run_full(rx_run);

  cbslc_run_counter u_rx_run (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_restart (i_rx_sof),
    .i_bit_stb (rx_take),
    .i_bit_val (rx_level),
    .o_run     (rx_run),
    .o_lvl     ()
  );

  // each taken bit is either passed on or dropped as stuff
  always_comb begin
    rx_valid_d = 1'b0;
    rx_stuff_d = 1'b0;
    rx_bit_d   = rx_bit_q;
    if (rx_take) begin
      if (rx_is_stuff) begin
        rx_stuff_d = 1'b1;
      end else begin
        rx_valid_d = 1'b1;
        rx_bit_d   = rx_level;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= rx_valid_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_stuff_q <= 1'b0;
    end else begin
      rx_stuff_q <= rx_stuff_d;
    end
  end

  // last destuffed bit holds between pulses
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_bit_q <= LVL_RECESSIVE;
    end else begin
      rx_bit_q <= rx_bit_d;
    end
  end

  assign o_rx_valid = rx_valid_q;
  assign o_rx_bit   = rx_bit_q;
  assign o_rx_stuff = rx_stuff_q;

endmodule

`default_nettype wire

/* File: rtl/cbslc_pkg.sv */
// package for the bit stuffing line coder: levels, run length, states
// assumes a single core clock domain; no register map exists
package cbslc_pkg;

  // ****************************************************************
  // line levels and run limits
  // ****************************************************************
  localparam logic       LVL_DOMINANT  = 1'b0;
  localparam logic       LVL_RECESSIVE = 1'b1;
  localparam int         RUN_LIMIT     = 5;
  localparam logic [2:0] RUN_LIMIT_C   = 3'h5;
  localparam logic [2:0] RUN_FIRST     = 3'h1;
  localparam logic [2:0] RUN_RESET     = 3'h0;

  // ****************************************************************
  // transmit state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    CBSLC_TX_IDLE  = 2'b00,
    CBSLC_TX_DATA  = 2'b01,
    CBSLC_TX_STUFF = 2'b10
  } cbslc_tx_e;

endpackage

/* File: rtl/cbslc_run_counter.sv */
// run length counter shared by the stuffing and destuffing paths
// assumes bits arrive as single-cycle strobes with the bit level beside
`timescale 1ns/1ps
`default_nettype none

module cbslc_run_counter (
  input  wire logic       i_clk_sys,  // core clock
  input  wire logic       i_nrst,     // async reset, active low
  input  wire logic       i_restart,  // start of frame: first bit of run
  input  wire logic       i_bit_stb,  // a bit on the line this cycle
  input  wire logic       i_bit_val,  // its level
  output logic [2:0]      o_run,      // length of current run incl. last bit
  output logic            o_lvl       // level of current run
);
  import cbslc_pkg::*;

  logic [2:0] run_q;
  logic       lvl_q;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      run_q <= RUN_RESET;
      lvl_q <= LVL_RECESSIVE;
    end else if (i_bit_stb) begin
      // a stuff bit opens a new run like any polarity change
      if (i_restart || i_bit_val != lvl_q || run_q == RUN_LIMIT_C) begin
        run_q <= RUN_FIRST;
      end else begin
        run_q <= run_q + 3'h1;
      end
      lvl_q <= i_bit_val;
    end
  end

  assign o_run = run_q;
  assign o_lvl = lvl_q;

endmodule

`default_nettype wire

/* File: bench/cbslc_monitor.sv */
// checker on the line coder ports: bus view, tx stuffing, rx destuffing
// assumes one clock, async active-low reset; bound below the module
`timescale 1ns/1ps
`default_nettype none
module cbslc_monitor (
  input wire logic i_clk_sys,      // clock
  input wire logic i_nrst,         // reset
  input wire logic i_bit_stb,      // strobe
  input wire logic i_tx_en,        // tx frame
  input wire logic i_tx_bit,       // tx bit
  input wire logic o_tx_ready,     // taken
  input wire logic i_rx_line,      // rx level
  input wire logic i_rx_sof,       // rx start
  input wire logic i_rx_en,        // rx frame
  input wire logic o_tx_line,      // tx level
  input wire logic o_bus_dominant, // bus view
  input wire logic o_rx_valid,     // rx pulse
  input wire logic o_rx_bit,       // rx bit
  input wire logic o_rx_stuff      // stuff pulse
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // run length of the line as it stands after each strobe inside a frame
  logic       shown_q;
  logic       run_lvl_q;
  logic [2:0] run_len_q;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      shown_q   <= 1'b0;
      run_lvl_q <= 1'b1;
      run_len_q <= 3'h0;
    end else begin
      shown_q <= i_bit_stb && i_tx_en;
      if (shown_q) begin
        run_lvl_q <= o_tx_line;
        if (o_tx_line != run_lvl_q || run_len_q == 3'h0) begin
          run_len_q <= 3'h1;
        end else if (run_len_q != 3'h7) begin
          run_len_q <= run_len_q + 3'h1;
        end
      end else if (!i_tx_en) begin
        run_len_q <= 3'h0;
      end
    end
  end
  a_bus_wired_and: assert property ($past(i_nrst) |->
    o_bus_dominant == (!$past(i_rx_line) || !$past(o_tx_line))) else $error("bus view wrong");
  a_run_max: assert property (run_len_q <= 3'h5) else $error("line run too long");
  a_tx_idle: assert property (i_bit_stb && !i_tx_en |=> o_tx_line) else $error("idle not recessive");
  a_tx_data: assert property (o_tx_ready |=> o_tx_line == $past(i_tx_bit)) else $error("tx bit wrong");
  a_tx_hold: assert property (!i_bit_stb |=> $stable(o_tx_line)) else $error("tx moved");
  a_stuff_flip: assert property (i_bit_stb && i_tx_en && !o_tx_ready |=> o_tx_line != $past(o_tx_line))
    else $error("stuff not opposite");
  a_rx_answer: assert property (i_bit_stb && (i_rx_en || i_rx_sof) |=> o_rx_valid != o_rx_stuff)
    else $error("rx no answer");
  a_rx_quiet: assert property (!i_bit_stb |=> !o_rx_valid && !o_rx_stuff) else $error("rx pulse unasked");
  a_rx_level: assert property (o_rx_valid |-> o_rx_bit == $past(i_rx_line && o_tx_line)) else $error("rx bit");
  a_sof_taken: assert property (i_bit_stb && i_rx_sof |=> o_rx_valid && !o_rx_stuff)
    else $error("start bit dropped");
endmodule
bind cbslc_line_coder cbslc_monitor cbslc_monitor_inst (.i_clk_sys, .i_nrst, .i_bit_stb, .i_tx_en, .i_tx_bit,
  .o_tx_ready, .i_rx_line, .i_rx_sof, .i_rx_en, .o_tx_line, .o_bus_dominant, .o_rx_valid, .o_rx_bit, .o_rx_stuff);
`default_nettype wire

/* File: bench/cbslc_bus_node.sv */
// other bus node: open-drain driver onto a bus with pull-up
// assumes the bus is shared with the coder's own line level
`timescale 1ns/1ps
`default_nettype none
module cbslc_bus_node (
  input  wire logic i_drive_dom, // drive dominant
  input  wire logic i_own_line,  // coder level
  output logic      o_bus        // resolved bus
);
  assign o_bus = !i_drive_dom && i_own_line;
endmodule
`default_nettype wire

/* File: bench/cbslc_line_coder_test.sv */
// bench for the line coder: tx frame, rx frame from a node, bus view
// assumes the partner node model and package constants
`timescale 1ns/1ps
`default_nettype none
module cbslc_line_coder_test;
  import cbslc_pkg::*;
  logic clk = 0, nrst = 0, stb = 0, ten = 0, sof = 0, tb = 1, ren = 0, drv = 0;
  wire  bus, rdy, tl, dom, rv, rb, rs;
  int   bad_count = 0, checked = 0;
  cbslc_line_coder cbslc_line_coder_inst (.i_clk_sys(clk), .i_nrst(nrst), .i_bit_stb(stb), .i_tx_en(ten),
    .i_tx_sof(sof), .i_tx_bit(tb), .o_tx_ready(rdy), .i_rx_line(bus), .i_rx_sof(sof), .i_rx_en(ren),
    .o_tx_line(tl), .o_bus_dominant(dom), .o_rx_valid(rv), .o_rx_bit(rb), .o_rx_stuff(rs));
  cbslc_bus_node cbslc_bus_node_inst (.i_drive_dom(drv), .i_own_line(tl), .o_bus(bus));
  initial forever #2 clk = ~clk;
  task chk(input logic s, input logic e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t: output mismatch", $time);
    end
  endtask
  task wrap_up;
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic slot(input logic t, input logic n, input logic s, output logic r);
    @(posedge clk);
    stb <= 1;
    tb <= t;
    drv <= !n;
    sof <= s;
    #1 r = rdy;
    @(posedge clk);
    stb <= 0;
    #1;
  endtask
  // the coder sends one frame; the expected stuffing is modelled here
  task automatic tx_frame(input logic [15:0] d);
    int   i = 0, run = 0;
    logic lvl = 1, ok, e, r;
    @(posedge clk);
    ten <= 1;
    while (i < 16) begin
      ok = run != RUN_LIMIT;
      e = ok ? d[i] : !lvl;
      slot(d[i], 1'b1, i == 0, r);
      chk(r, ok);
      chk(tl, e);
      run = (e == lvl) ? run + 1 : 1;
      lvl = e;
      if (ok) i++;
    end
    @(posedge clk);
    ten <= 0;
    slot(1'b1, 1'b1, 1'b0, r);
    chk(tl, 1'b1);
  endtask
  // the node sends one stuffed frame; the coder must drop exactly the stuff bits
  task automatic rx_frame(input logic [15:0] d);
    int   i = 0, run = 0;
    logic lvl = 1, ok, e, r;
    @(posedge clk);
    ren <= 1;
    while (i < 16) begin
      ok = run != RUN_LIMIT;
      e = ok ? d[i] : !lvl;
      slot(1'b1, e, i == 0, r);
      chk(rs, !ok);
      chk(rv, ok);
      if (ok) chk(rb, e);
      run = (e == lvl) ? run + 1 : 1;
      lvl = e;
      if (ok) i++;
    end
    @(posedge clk);
    ren <= 0;
    slot(1'b1, 1'b1, 1'b0, r);
    chk(tl, 1'b1);
  endtask
  task automatic wand_check;
    @(posedge clk);
    drv <= 1;
    repeat (2) @(posedge clk);
    #1 chk(dom, 1'b1);
    @(posedge clk);
    drv <= 0;
    repeat (2) @(posedge clk);
    #1 chk(dom, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    tx_frame(16'h83e0);
    tx_frame(16'hff00);
    rx_frame(16'h83e0);
    rx_frame(16'hff00);
    wand_check;
    wrap_up;
  end
  initial begin
    #4000;
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
